//--- design/pps_pkg.sv
// Package for the port PHY status and cable diagnostic register bank.
// Assumes a 16-bit register port addressed by a bank number and an even byte offset.
package pps_pkg;

    // Bank numbers that this block answers to.
    localparam logic [5:0] BANK_P1_PHY = 6'h31;
    localparam logic [5:0] BANK_P2_CTL = 6'h32;
    localparam logic [5:0] BANK_P2_PHY = 6'h33;

    // Offsets inside a bank.
    localparam logic [3:0] OFF_STATUS  = 4'h4;
    localparam logic [3:0] OFF_DIAG    = 4'h0;
    localparam logic [3:0] OFF_CTL_MAX = 4'ha;
    localparam int         NUM_CTL     = 6;
    localparam int         ADDR_W      = 10;
    localparam int         DATA_W      = 16;

    // First port status word bit positions.
    localparam int ST_XSEL = 15;
    localparam int ST_POL  = 13;
    localparam int ST_RXFC = 12;
    localparam int ST_TXFC = 11;
    localparam int ST_SPD  = 10;
    localparam int ST_DPX  = 9;
    localparam int ST_FEF  = 8;
    localparam int ST_MDIX = 7;
    localparam int ST_LINK = 5;
    localparam int ST_ABIL = 0;
    localparam int ABIL_W  = 5;

    // Second port diagnostic word bit positions.
    localparam int DG_SHORT = 15;
    localparam int DG_RES   = 13;
    localparam int DG_EN    = 12;
    localparam int DG_FORCE = 11;
    localparam int DG_PWR   = 10;
    localparam int DG_LOOP  = 9;
    localparam int DG_CNT   = 0;
    localparam int CNT_W    = 9;

    // Cable test result codes.
    localparam logic [1:0] RES_NORMAL = 2'h0;
    localparam logic [1:0] RES_OPEN   = 2'h1;
    localparam logic [1:0] RES_SHORT  = 2'h2;
    localparam logic [1:0] RES_FAILED = 2'h3;

    // Reset values.
    localparam logic              XSEL_RST  = 1'h1;
    localparam logic              PWR_RST   = 1'h1;
    localparam logic              FORCE_RST = 1'h0;
    localparam logic              LOOP_RST  = 1'h0;
    localparam logic [DATA_W-1:0] CTL_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    // Cable test sequencer states.
    typedef enum logic [1:0] {
        PPS_IDLE = 2'h0,
        PPS_RUN  = 2'h1
    } pps_cdt_e;

endpackage

//--- design/pps_rw_word.sv
// One plain read/write register word with a load strobe.
// Assumes the caller decodes the address and presents a one-cycle write strobe.
`timescale 1ns/100ps
module pps_rw_word #(
    parameter logic [15:0] RST_VAL = 16'h0000
) (
    input  wire logic        clk,     // System clock.
    input  wire logic        rst_n,   // Asynchronous reset, active low.
    input  wire logic        we,      // Load strobe.
    input  wire logic [15:0] wdata,   // Value to load.
    output logic      [15:0] q        // Stored word.
);

    // The word loads on its strobe and holds otherwise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= RST_VAL;
        end else if (we) begin
            q <= wdata;
        end
    end

endmodule

//--- design/pps_port_phy_regs.sv
// Port PHY status, second port control words and cable diagnostic control.
// Assumes PHY status and cable test answers arrive asynchronously on pins,
// and a register master that never issues read and write together.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module pps_port_phy_regs (
    input  wire logic        clk,                        // System clock, 100 MHz.
    input  wire logic        rst_n,                      // Asynchronous reset, active low.
    input  wire logic [9:0]  addr,                       // Bank in 9:4, byte offset in 3:0.
    input  wire logic [15:0] wdata,                      // Write data.
    input  wire logic        wr,                         // Write strobe.
    input  wire logic        rd,                         // Read strobe.
    output logic      [15:0] rdata,                      // Read data, cycle after rd.
    input  wire logic        p1_polarity_rev,            // Receive pair reversed.
    input  wire logic        p1_rx_pause,                // Receive pause active.
    input  wire logic        p1_tx_pause,                // Transmit pause active.
    input  wire logic        p1_speed_100,               // Resolved 100 Mbps.
    input  wire logic        p1_full_duplex,             // Resolved full duplex.
    input  wire logic        p1_far_end_fault,           // Far end fault seen.
    input  wire logic        p1_mdix,                    // Crossed wiring in use.
    input  wire logic        p1_link_good,               // Link established.
    input  wire logic [4:0]  p1_partner_abil,            // Partner abilities.
    input  wire logic        p2_cable_done,              // Cable test finished, level.
    input  wire logic [1:0]  p2_cable_result,            // Cable test result code.
    input  wire logic        p2_cable_near_short,        // Short closer than 10 m.
    input  wire logic [8:0]  p2_fault_count,             // Distance to fault.
    output logic             crossover_algorithm_select, // Crossover scheme select.
    output logic             p2_cable_test_start,        // One-cycle test start.
    output logic             p2_force_link,              // Force link pass.
    output logic             p2_pwrsave_disable,         // Power saving disabled.
    output logic             p2_near_loopback,           // Near end loopback.
    output logic      [15:0] p2_control_one,             // Control word at 0x0.
    output logic      [15:0] p2_control_two,             // Control word at 0x2.
    output logic      [15:0] p2_vlan_id_control,         // VLAN word at 0x4.
    output logic      [15:0] p2_control_three,           // Control word at 0x6.
    output logic      [15:0] p2_ingress_rate,            // Ingress rate at 0x8.
    output logic      [15:0] p2_egress_rate              // Egress rate at 0xa.
);

    localparam int EXT_W  = 26;
    localparam int X_DONE = 12;
    localparam int X_RES  = 10;
    localparam int X_SHRT = 9;
    localparam int X_POL  = 25;
    localparam int X_RXFC = 24;
    localparam int X_TXFC = 23;
    localparam int X_SPD  = 22;
    localparam int X_DPX  = 21;
    localparam int X_FEF  = 20;
    localparam int X_MDIX = 19;
    localparam int X_LINK = 18;
    localparam int X_ABIL = 13;

    logic [EXT_W-1:0]  ext_meta_reg;
    logic [EXT_W-1:0]  ext_sync_reg;
    logic              done_prev_reg;
    logic              done_rise;
    logic [5:0]        bank;
    logic [3:0]        offs;
    logic              hit_status;
    logic              hit_diag;
    logic              hit_ctl;
    logic              wr_diag;
    logic              cdt_go;
    logic [2:0]        ctl_idx;
    logic [pps_pkg::NUM_CTL-1:0] ctl_we;
    logic [15:0]       ctl_q [pps_pkg::NUM_CTL];
    logic              xsel_reg;
    logic              force_reg;
    logic              pwr_reg;
    logic              loop_reg;
    logic              start_reg;
    logic              short_reg;
    logic [1:0]        res_reg;
    logic [8:0]        cnt_reg;
    logic [15:0]       rdata_reg;
    logic [15:0]       rdata_next;
    logic [15:0]       status_word;
    logic [15:0]       diag_word;
    pps_pkg::pps_cdt_e state_reg;

    // Every pin input passes two flip-flops; the first stage feeds only the second.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_reg <= '0;
            ext_sync_reg <= '0;
        end else begin
            ext_meta_reg <= {p1_polarity_rev, p1_rx_pause, p1_tx_pause, p1_speed_100,
                             p1_full_duplex, p1_far_end_fault, p1_mdix, p1_link_good,
                             p1_partner_abil, p2_cable_done, p2_cable_result,
                             p2_cable_near_short, p2_fault_count};
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // Edge detect on the synchronised done level.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_prev_reg <= 1'h0;
        end else begin
            done_prev_reg <= ext_sync_reg[X_DONE];
        end
    end
    assign done_rise = ext_sync_reg[X_DONE] & ~done_prev_reg;

    // Address decode; odd offsets and other banks are unmapped.
    assign bank       = addr[9:4];
    assign offs       = addr[3:0];
    assign hit_status = (bank == pps_pkg::BANK_P1_PHY) && (offs == pps_pkg::OFF_STATUS);
    assign hit_diag   = (bank == pps_pkg::BANK_P2_PHY) && (offs == pps_pkg::OFF_DIAG);
    assign hit_ctl    = (bank == pps_pkg::BANK_P2_CTL) && !offs[0]
                        && (offs <= pps_pkg::OFF_CTL_MAX);
    assign ctl_idx    = offs[3:1];
    assign wr_diag    = wr && hit_diag;
    assign cdt_go     = wr_diag && wdata[pps_pkg::DG_EN] && (state_reg == pps_pkg::PPS_IDLE);

    // Second port control words share one storage module each.
    genvar gi;
    generate
        for (gi = 0; gi < pps_pkg::NUM_CTL; gi++) begin : g_ctl
            assign ctl_we[gi] = wr && hit_ctl && (ctl_idx == 3'(gi));
            pps_rw_word #(
                .RST_VAL (pps_pkg::CTL_RST)
            ) u_word (
                .clk   (clk),
                .rst_n (rst_n),
                .we    (ctl_we[gi]),
                .wdata (wdata),
                .q     (ctl_q[gi])
            );
        end
    endgenerate

    // Only bit 15 of the status word is writable; the rest ignore writes.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xsel_reg <= pps_pkg::XSEL_RST;
        end else if (wr && hit_status) begin
            xsel_reg <= wdata[pps_pkg::ST_XSEL];
        end
    end

    // Plain control bits of the diagnostic word.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            force_reg <= pps_pkg::FORCE_RST;
            pwr_reg   <= pps_pkg::PWR_RST;
            loop_reg  <= pps_pkg::LOOP_RST;
        end else if (wr_diag) begin
            force_reg <= wdata[pps_pkg::DG_FORCE];
            pwr_reg   <= wdata[pps_pkg::DG_PWR];
            loop_reg  <= wdata[pps_pkg::DG_LOOP];
        end
    end

    // Test sequencer; the enable bit reads one while running and a zero write
    // cannot abort a test, since the analog side has no cancel.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pps_pkg::PPS_IDLE;
        end else begin
            case (state_reg)
                pps_pkg::PPS_IDLE: begin
                    if (cdt_go) begin
                        state_reg <= pps_pkg::PPS_RUN;
                    end
                end
                pps_pkg::PPS_RUN: begin
                    if (done_rise) begin
                        state_reg <= pps_pkg::PPS_IDLE;
                    end
                end
                default: begin
                    state_reg <= pps_pkg::PPS_IDLE;
                end
            endcase
        end
    end

    // Start pulse to the cable tester, one cycle long.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_reg <= 1'h0;
        end else begin
            start_reg <= cdt_go;
        end
    end

    // Results are captured together with the finish, so a read sees them consistent.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            short_reg <= 1'h0;
            res_reg   <= pps_pkg::RES_NORMAL;
            cnt_reg   <= '0;
        end else if ((state_reg == pps_pkg::PPS_RUN) && done_rise) begin
            short_reg <= ext_sync_reg[X_SHRT];
            res_reg   <= ext_sync_reg[X_RES +: 2];
            cnt_reg   <= ext_sync_reg[pps_pkg::CNT_W-1:0];
        end
    end

    // Status word; reserved positions 14 and 6 stay zero.
    always_comb begin
        status_word                  = pps_pkg::ZERO_WORD;
        status_word[pps_pkg::ST_XSEL] = xsel_reg;
        status_word[pps_pkg::ST_POL]  = ext_sync_reg[X_POL];
        status_word[pps_pkg::ST_RXFC] = ext_sync_reg[X_RXFC];
        status_word[pps_pkg::ST_TXFC] = ext_sync_reg[X_TXFC];
        status_word[pps_pkg::ST_SPD]  = ext_sync_reg[X_SPD];
        status_word[pps_pkg::ST_DPX]  = ext_sync_reg[X_DPX];
        status_word[pps_pkg::ST_FEF]  = ext_sync_reg[X_FEF];
        status_word[pps_pkg::ST_MDIX] = ext_sync_reg[X_MDIX];
        status_word[pps_pkg::ST_LINK] = ext_sync_reg[X_LINK];
        status_word[pps_pkg::ST_ABIL +: pps_pkg::ABIL_W] =
            ext_sync_reg[X_ABIL +: pps_pkg::ABIL_W];
    end

    // Diagnostic word as software sees it.
    always_comb begin
        diag_word                                 = pps_pkg::ZERO_WORD;
        diag_word[pps_pkg::DG_SHORT]              = short_reg;
        diag_word[pps_pkg::DG_RES +: 2]           = res_reg;
        diag_word[pps_pkg::DG_EN]                 = (state_reg == pps_pkg::PPS_RUN);
        diag_word[pps_pkg::DG_FORCE]              = force_reg;
        diag_word[pps_pkg::DG_PWR]                = pwr_reg;
        diag_word[pps_pkg::DG_LOOP]               = loop_reg;
        diag_word[pps_pkg::DG_CNT +: pps_pkg::CNT_W] = cnt_reg;
    end

    // Read multiplexer; unmapped reads and idle cycles give zero.
    always_comb begin
        rdata_next = pps_pkg::ZERO_WORD;
        if (rd) begin
            if (hit_status) begin
                rdata_next = status_word;
            end else if (hit_diag) begin
                rdata_next = diag_word;
            end else if (hit_ctl && (ctl_idx < 3'(pps_pkg::NUM_CTL))) begin
                rdata_next = ctl_q[ctl_idx];
            end
        end
    end

    // Read data register, valid only in the cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= pps_pkg::ZERO_WORD;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata                      = rdata_reg;
    assign crossover_algorithm_select = xsel_reg;
    assign p2_cable_test_start        = start_reg;
    assign p2_force_link              = force_reg;
    assign p2_pwrsave_disable         = pwr_reg;
    assign p2_near_loopback           = loop_reg;
    assign p2_control_one             = ctl_q[0];
    assign p2_control_two             = ctl_q[1];
    assign p2_vlan_id_control         = ctl_q[2];
    assign p2_control_three           = ctl_q[3];
    assign p2_ingress_rate            = ctl_q[4];
    assign p2_egress_rate             = ctl_q[5];

    // Checks on the bank behaviour.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_ctl_write;
        wr && hit_ctl;
    endsequence
    sequence s_same_read;
        rd && hit_ctl && (addr == $past(addr));
    endsequence
    sequence s_test_req;
        cdt_go;
    endsequence

    property p_xsel_rw;
        (wr && hit_status) ##1 (rd && hit_status)
            |=> rdata[pps_pkg::ST_XSEL] == $past(wdata[pps_pkg::ST_XSEL], 2);
    endproperty
    a_xsel_rw: assert property (p_xsel_rw) else $error("Crossover select read back wrong.");

    property p_reserved_zero;
        rd && hit_status |=> !rdata[14] && !rdata[6];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved status bit set.");

    property p_link_read;
        rd && hit_status |=> rdata[pps_pkg::ST_LINK] == $past(ext_sync_reg[18]);
    endproperty
    a_link_read: assert property (p_link_read) else $error("Link good read wrong.");

    property p_start_pulse;
        s_test_req |=> start_reg && (state_reg == pps_pkg::PPS_RUN) ##1 !start_reg;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("Start pulse wrong.");

    property p_en_reads_one;
        s_test_req ##1 (rd && hit_diag && !done_rise) |=> rdata[pps_pkg::DG_EN];
    endproperty
    a_en_reads_one: assert property (p_en_reads_one) else $error("Enable bit low in test.");

    property p_self_clear;
        (state_reg == pps_pkg::PPS_RUN) && done_rise |=> (state_reg == pps_pkg::PPS_IDLE)
            && cnt_reg == $past(ext_sync_reg[8:0]) && res_reg == $past(ext_sync_reg[11:10]);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("Test end not handled.");

    property p_diag_ctl;
        wr_diag |=> force_reg == $past(wdata[11]) && pwr_reg == $past(wdata[10])
            && loop_reg == $past(wdata[9]);
    endproperty
    a_diag_ctl: assert property (p_diag_ctl) else $error("Diag control bits wrong.");

    property p_ctl_rw;
        s_ctl_write ##1 s_same_read |=> rdata == $past(wdata, 2);
    endproperty
    a_ctl_rw: assert property (p_ctl_rw) else $error("Control word read back wrong.");

    property p_idle_zero;
        !rd |=> rdata == 16'h0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("Read data not zero.");

endmodule

//--- bench/pps_phy_model.sv
// Behavioural far-side PHY that answers cable tests for the register bank.
// Assumes a one-cycle start pulse and results chosen by the bench.
`timescale 1ns/100ps
module pps_phy_model #(
    parameter int DLY = 12                // Cycles from start to results.
) (
    input  wire logic       clk,          // System clock.
    input  wire logic       rst_n,        // Reset, active low.
    input  wire logic       start,        // Test start pulse.
    input  wire logic [1:0] res_cfg,      // Result code to report.
    input  wire logic       sh_cfg,       // Near short to report.
    input  wire logic [8:0] cnt_cfg,      // Fault distance to report.
    output logic            done,         // Test finished level.
    output logic      [1:0] res,          // Result code pins.
    output logic            sh,           // Near short pin.
    output logic      [8:0] cnt           // Fault distance pins.
);
    int t_reg;

    // Fields hold from the start pulse until a few cycles after done rises; outside that window they
    // toggle, so a design that samples late or never latches reads junk.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            t_reg <= -1;
            done  <= 1'h0;
            res   <= 2'h0;
            sh    <= 1'h0;
            cnt   <= 9'h000;
        end else if (start) begin
            t_reg <= 0;
            done  <= 1'h0;
        end else if (t_reg >= 0) begin
            t_reg <= (t_reg < DLY + 5) ? t_reg + 1 : -1;
            if (t_reg == DLY) begin
                res <= res_cfg;
                sh  <= sh_cfg;
                cnt <= cnt_cfg;
            end
            if (t_reg == DLY + 1) begin
                done <= 1'h1;
            end
        end else begin
            res <= ~res;
            sh  <= ~sh;
            cnt <= ~cnt;
        end
    end
endmodule

//--- bench/pps_port_phy_regs_tb.sv
// Self-checking bench for the port PHY status and cable diagnostic bank.
// Assumes the package, the design and the far-side PHY model are compiled first.
`timescale 1ns/100ps
module pps_port_phy_regs_tb;
    typedef struct packed {
        logic [12:0] st;   // Status pins, polarity down to abilities.
        logic [15:0] exp;  // Status word expected.
    } pps_row_s;

    logic             clk = 1'h0;
    logic             rst_n = 1'h0;
    logic [9:0]       addr = 10'h000;
    logic [15:0]      wdata = 16'h0000;
    logic             wr = 1'h0;
    logic             rd = 1'h0;
    logic [12:0]      st = 13'h0000;
    logic [1:0]       res_cfg = 2'h0;
    logic             sh_cfg = 1'h0;
    logic [8:0]       cnt_cfg = 9'h000;
    logic [15:0]      rdata;
    wire  [15:0]      ctl [6];
    logic             start, done, force_l, pwr, loop_b, xsel, sh;
    logic [1:0]       res;
    logic [8:0]       cnt;
    int               n_fail = 0;
    int               num_checks = 0;
    int               cyc = 0;
    pps_row_s         rows [12];

    pps_port_phy_regs i_pps_port_phy_regs (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .p1_polarity_rev(st[12]), .p1_rx_pause(st[11]),
        .p1_tx_pause(st[10]), .p1_speed_100(st[9]), .p1_full_duplex(st[8]),
        .p1_far_end_fault(st[7]), .p1_mdix(st[6]), .p1_link_good(st[5]),
        .p1_partner_abil(st[4:0]), .p2_cable_done(done), .p2_cable_result(res),
        .p2_cable_near_short(sh), .p2_fault_count(cnt),
        .crossover_algorithm_select(xsel), .p2_cable_test_start(start),
        .p2_force_link(force_l), .p2_pwrsave_disable(pwr), .p2_near_loopback(loop_b),
        .p2_control_one(ctl[0]), .p2_control_two(ctl[1]), .p2_vlan_id_control(ctl[2]),
        .p2_control_three(ctl[3]), .p2_ingress_rate(ctl[4]), .p2_egress_rate(ctl[5]));

    pps_phy_model #(.DLY(12)) i_pps_phy_model (
        .clk(clk), .rst_n(rst_n), .start(start), .res_cfg(res_cfg), .sh_cfg(sh_cfg),
        .cnt_cfg(cnt_cfg), .done(done), .res(res), .sh(sh), .cnt(cnt));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // A hang is cut short well after the few hundred cycles the run needs.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            end_sim();
        end
    end

    // Every result is a word; single flags are zero-extended first.
    task automatic chk_word(input logic [15:0] got, input logic [15:0] want);
        num_checks++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'h0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe, so sample there.
    task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk);
        rd   <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask

    // Write then read the same word on adjacent edges, strobes back to back.
    task automatic wr_rd(input logic [9:0] a, input logic [15:0] w, output logic [15:0] d);
        @(posedge clk);
        wr    <= 1'h1;
        addr  <= a;
        wdata <= w;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1;
        d = rdata;
    endtask

    // One full test, with a second start request made while it runs.
    task automatic cable_test(input logic [1:0] c, input logic s, input logic [8:0] n);
        logic [15:0] d;
        int          k;
        res_cfg <= c;
        sh_cfg  <= s;
        cnt_cfg <= n;
        wr_reg(10'h330, 16'h1a00);
        chk_word({15'h0000, start}, 16'h0001);
        chk_word({13'h0000, force_l, pwr, loop_b}, 16'h0005);
        wr_reg(10'h330, 16'h1a00);
        chk_word({15'h0000, start}, 16'h0000);
        rd_reg(10'h330, d);
        chk_word(d & 16'h1000, 16'h1000);
        k = 0;
        while (d[12] !== 1'h0 && k < 60) begin
            rd_reg(10'h330, d);
            k++;
        end
        repeat (8) @(posedge clk);
        rd_reg(10'h330, d);
        chk_word(d, {s, c, 1'h0, 1'h1, 1'h0, 1'h1, n});
    endtask

    task automatic end_sim();
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence: reset values, status table, then hand-written cases.
    initial begin
        logic [15:0] d;
        rows = '{'{13'h0000, 16'h8000}, '{13'h1000, 16'ha000}, '{13'h0800, 16'h9000},
                 '{13'h0400, 16'h8800}, '{13'h0200, 16'h8400}, '{13'h0100, 16'h8200},
                 '{13'h0080, 16'h8100}, '{13'h0040, 16'h8080}, '{13'h0020, 16'h8020},
                 '{13'h0012, 16'h8012}, '{13'h000d, 16'h800d}, '{13'h1fff, 16'hbfbf}};
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(10'h330, d);
        chk_word(d, 16'h0400);
        chk_word({12'h000, xsel, pwr, force_l, loop_b}, 16'h000c);
        for (int i = 0; i < 6; i++) begin
            rd_reg(10'h320 + 10'(2 * i), d);
            chk_word(d, 16'h0000);
        end
        // Status pins pass two sync flops before they show in the word.
        foreach (rows[i]) begin
            @(posedge clk);
            st <= rows[i].st;
            repeat (4) @(posedge clk);
            rd_reg(10'h314, d);
            chk_word(d, rows[i].exp);
        end
        // Adjacent write and read, so the read-back checks in the design get exercised.
        wr_rd(10'h314, 16'h7fff, d);
        chk_word(d, 16'h3fbf);
        chk_word({15'h0000, xsel}, 16'h0000);
        wr_reg(10'h314, 16'h8000);
        chk_word({15'h0000, xsel}, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            wr_rd(10'h320 + 10'(2 * i), 16'ha5a0 + 16'(i), d);
            chk_word(d, 16'ha5a0 + 16'(i));
        end
        wr_reg(10'h321, 16'hffff);
        wr_reg(10'h300, 16'hffff);
        for (int i = 0; i < 6; i++) begin
            rd_reg(10'h320 + 10'(2 * i), d);
            chk_word(d, 16'ha5a0 + 16'(i));
            chk_word(ctl[i], 16'ha5a0 + 16'(i));
        end
        rd_reg(10'h321, d);
        chk_word(d, 16'h0000);
        rd_reg(10'h300, d);
        chk_word(d, 16'h0000);
        // Read-only fields set, bit 12 clear: only force, power-save and loopback may change.
        wr_reg(10'h330, 16'hebff);
        chk_word({15'h0000, start}, 16'h0000);
        rd_reg(10'h330, d);
        chk_word(d, 16'h0a00);
        chk_word({13'h0000, force_l, pwr, loop_b}, 16'h0005);
        cable_test(2'h0, 1'h0, 9'h000);
        cable_test(2'h1, 1'h1, 9'h1ff);
        cable_test(2'h2, 1'h1, 9'h0a5);
        cable_test(2'h3, 1'h0, 9'h15a);
        // Reset in the middle of a running test must abandon it cleanly.
        wr_reg(10'h330, 16'h1000);
        @(posedge clk);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(10'h330, d);
        chk_word(d, 16'h0400);
        repeat (3) @(posedge clk);
        rd_reg(10'h314, d);
        chk_word(d, 16'hbfbf);
        end_sim();
    end
endmodule
